// [pkg/tcbq_pkg.sv]
// constants and types for the channel buffer and error queue block
`default_nettype none
package tcbq_pkg;
   // ==========================================================
   // register map: byte address = channel * 0x20 + index * 4
   localparam int          CH_SHIFT         = 5;
   localparam logic [2:0]  REG_ERR_CTRL     = 3'h0;
   localparam logic [2:0]  REG_ERR_COUNT    = 3'h1;
   localparam logic [2:0]  REG_ERR_QUEUE    = 3'h2;
   localparam logic [2:0]  REG_ENABLE       = 3'h3;
   localparam logic [2:0]  REG_BUF_BASE     = 3'h4;
   localparam logic [2:0]  REG_FRAME_STRIDE = 3'h5;
   localparam logic [2:0]  REG_FRAME_BYTES  = 3'h6;
   localparam logic [2:0]  REG_FRAMES       = 3'h7;
   localparam logic [11:0] OFS_CFG_STATUS   = 12'h100;
   // ==========================================================
   // field positions and widths
   localparam int BIT_POP       = 0;
   localparam int BIT_FLUSH     = 1;
   localparam int BIT_OVF_CLEAR = 8;
   localparam int BIT_OVF_FLAG  = 8;
   localparam int BIT_RUN       = 0;
   localparam int CID_LSB       = 8;
   localparam int CNT_W         = 5;
   localparam int ENTRY_W       = 32;
   // ==========================================================
   // reset values
   localparam logic [29:0] RST_BASE   = 30'h0;
   localparam logic [9:0]  RST_STRIDE = 10'h0;
   localparam logic [9:0]  RST_BYTES  = 10'h0;
   localparam logic [7:0]  RST_FRAMES = 8'h0;
   localparam logic [7:0]  RST_CID    = 8'h0;
   // ==========================================================
   // encodings
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      CAT_CODE_ONLY  = 2'b00,
      CAT_FRAME_TIME = 2'b01,
      CAT_CID_PAIR   = 2'b10,
      CAT_CID_ACTIVE = 2'b11
   } tcbq_err_cat_t;
   typedef enum logic [1:0] {
      CS_NONE = 2'b00,
      CS_A    = 2'b01,
      CS_B    = 2'b10
   } tcbq_cfg_status_t;
endpackage
`default_nettype wire

// [pkg/tcbq_eq_if.sv]
// link between the channel logic and one error queue
`default_nettype none
interface tcbq_eq_if;
   import tcbq_pkg::*;
   logic                 push;
   logic [ENTRY_W-1:0]   push_data;
   logic                 pop;
   logic                 flush;
   logic                 full;
   logic [CNT_W-1:0]     count;
   logic [ENTRY_W-1:0]   head;
   modport ctrl  (output push, push_data, pop, flush, input full, count, head);
   modport queue (input push, push_data, pop, flush, output full, count, head);
endinterface
`default_nettype wire

// [hw/tcbq_err_queue.sv]
// per-channel error entry fifo
`default_nettype none
module tcbq_err_queue
   import tcbq_pkg::*;
#(
   parameter int DEPTH = 16
) (
   input  wire logic  i_core_clk,
   input  wire logic  i_sys_rst,
   tcbq_eq_if.queue   eq
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [ENTRY_W-1:0] mem_ff [DEPTH];
   logic [PTR_W-1:0]   rd_ff;
   logic [PTR_W-1:0]   wr_ff;
   logic [CNT_W-1:0]   cnt_ff;
   logic               pop_ok;
   logic               push_ok;

   // ==========================================================
   // handshake terms
   assign eq.full  = (cnt_ff == CNT_W'(DEPTH));
   assign eq.count = cnt_ff;
   assign eq.head  = (cnt_ff == '0) ? '0 : mem_ff[rd_ff];
   assign pop_ok   = eq.pop && (cnt_ff != '0) && !eq.flush;
   // a pop in the same cycle makes room for the new entry
   assign push_ok  = eq.push && (!eq.full || pop_ok || eq.flush);

   // ==========================================================
   // pointers and count
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rd_ff  <= '0;
         wr_ff  <= '0;
         cnt_ff <= '0;
      end else if (eq.flush) begin
         // entry arriving with a flush survives it
         rd_ff  <= wr_ff;
         wr_ff  <= wr_ff + PTR_W'(push_ok);
         cnt_ff <= CNT_W'(push_ok);
      end else begin
         rd_ff  <= rd_ff + PTR_W'(pop_ok);
         wr_ff  <= wr_ff + PTR_W'(push_ok);
         cnt_ff <= cnt_ff + CNT_W'(push_ok) - CNT_W'(pop_ok);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (push_ok) begin
         mem_ff[wr_ff] <= eq.push_data;
      end
   end
endmodule
`default_nettype wire

// [hw/tcbq_channel_ctx.sv]
// channel context, frame buffer walk and error queues behind an axi4-lite slave
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`default_nettype none
module tcbq_channel_ctx
   import tcbq_pkg::*;
#(
   parameter int NUM_CH   = 6,
   parameter int Q_DEPTH  = 16,
   parameter int ADDR_W   = 12,
   parameter int CH_W     = 3
) (
   input  wire logic                   i_core_clk,
   input  wire logic                   i_sys_rst,
   // register bus
   input  wire logic [ADDR_W-1:0]      i_awaddr,
   input  wire logic                   i_awvalid,
   output logic                        o_awready,
   input  wire logic [31:0]            i_wdata,
   input  wire logic [3:0]             i_wstrb,
   input  wire logic                   i_wvalid,
   output logic                        o_wready,
   output logic [1:0]                  o_bresp,
   output logic                        o_bvalid,
   input  wire logic                   i_bready,
   input  wire logic [ADDR_W-1:0]      i_araddr,
   input  wire logic                   i_arvalid,
   output logic                        o_arready,
   output logic [31:0]                 o_rdata,
   output logic [1:0]                  o_rresp,
   output logic                        o_rvalid,
   input  wire logic                   i_rready,
   // transfer engine side
   input  wire logic                   i_superframe_sync,
   input  wire logic [NUM_CH-1:0]      i_frame_advance,
   input  wire logic [23:0]            i_frame_counter,
   input  wire logic                   i_err_valid,
   input  wire logic [CH_W-1:0]        i_err_ch,
   input  wire logic [1:0]             i_err_cat,
   input  wire logic [7:0]             i_err_code,
   input  wire logic [7:0]             i_err_buf_cid,
   output logic [NUM_CH-1:0]           o_channel_run,
   output logic [NUM_CH-1:0]           o_config_set_b,
   output logic [NUM_CH*8-1:0]         o_active_config_id,
   output logic [NUM_CH*32-1:0]        o_frame_addr,
   output logic [NUM_CH*12-1:0]        o_frame_byte_count,
   output logic [NUM_CH*2-1:0]         o_config_set_active_status
);

   // ==========================================================
   // bus channel registers
   logic               bvalid_ff;
   logic [1:0]         bresp_ff;
   logic               rvalid_ff;
   logic [31:0]        rdata_ff;
   logic [1:0]         rresp_ff;

   // ==========================================================
   // address decode
   logic               wr_fire;
   logic               rd_fire;
   logic [CH_W-1:0]    wr_ch;
   logic [2:0]         wr_reg;
   logic               wr_chan_hit;
   logic               wr_glob_hit;
   logic [CH_W-1:0]    rd_ch;
   logic [2:0]         rd_reg;
   logic               rd_chan_hit;
   logic               rd_glob_hit;
   logic [31:0]        wmask;
   logic [31:0]        rd_word;
   logic [NUM_CH-1:0]  wr_sel;
   logic               wr_page0;
   logic               wr_ch_ok;
   logic               rd_page0;
   logic               rd_ch_ok;
   logic               wr_map_hit;
   logic               rd_map_hit;
   logic [31:0]        chan_rd_word;

   assign wr_fire     = i_awvalid && i_wvalid && !bvalid_ff;
   assign rd_fire     = i_arvalid && !rvalid_ff;
   assign o_awready   = wr_fire;
   assign o_wready    = wr_fire;
   assign o_arready   = !rvalid_ff;
   assign o_bvalid    = bvalid_ff;
   assign o_bresp     = bresp_ff;
   assign o_rvalid    = rvalid_ff;
   assign o_rdata     = rdata_ff;
   assign o_rresp     = rresp_ff;

   assign wr_ch       = i_awaddr[CH_SHIFT +: CH_W];
   assign wr_reg      = i_awaddr[4:2];
   assign wr_page0    = (i_awaddr[ADDR_W-1:CH_SHIFT+CH_W] == '0);
   assign wr_ch_ok    = (int'(wr_ch) < NUM_CH);
   assign wr_chan_hit = wr_page0 && wr_ch_ok;
   assign wr_glob_hit = (i_awaddr[ADDR_W-1:2] == OFS_CFG_STATUS[ADDR_W-1:2]);
   assign wr_map_hit  = wr_chan_hit || wr_glob_hit;

   assign rd_ch       = i_araddr[CH_SHIFT +: CH_W];
   assign rd_reg      = i_araddr[4:2];
   assign rd_page0    = (i_araddr[ADDR_W-1:CH_SHIFT+CH_W] == '0);
   assign rd_ch_ok    = (int'(rd_ch) < NUM_CH);
   assign rd_chan_hit = rd_page0 && rd_ch_ok;
   assign rd_glob_hit = (i_araddr[ADDR_W-1:2] == OFS_CFG_STATUS[ADDR_W-1:2]);
   assign rd_map_hit  = rd_chan_hit || rd_glob_hit;

   assign wmask       = {{8{i_wstrb[3]}}, {8{i_wstrb[2]}}, {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};

   // ==========================================================
   // per-channel state
   logic [31:0]        chan_word [NUM_CH][8];
   logic [7:0]         active_cid [NUM_CH];
   logic [1:0]         cfg_status [NUM_CH];
   logic [31:0]        status_word;

   // ==========================================================
   // error entry assembly
   logic [ENTRY_W-1:0] err_entry;
   logic [7:0]         err_active_cid;

   assign err_active_cid = (int'(i_err_ch) < NUM_CH) ? active_cid[i_err_ch] : 8'h00;

   always_comb begin
      err_entry = {i_err_code, 24'h000000};
      case (tcbq_err_cat_t'(i_err_cat))
         CAT_CODE_ONLY: begin
            err_entry = {i_err_code, 24'h000000};
         end
         CAT_FRAME_TIME: begin
            err_entry = {i_err_code, i_frame_counter};
         end
         CAT_CID_PAIR: begin
            err_entry = {i_err_code, 8'h00, err_active_cid, i_err_buf_cid};
         end
         CAT_CID_ACTIVE: begin
            err_entry = {i_err_code, 16'h0000, err_active_cid};
         end
         default: begin
            err_entry = {i_err_code, 24'h000000};
         end
      endcase
   end

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_ch
         tcbq_eq_if eq_bus ();

         logic        run_ff;
         logic [7:0]  next_cid_ff;
         logic [7:0]  active_cid_ff;
         logic [29:0] base_ff;
         logic [9:0]  stride_ff;
         logic [9:0]  bytes_ff;
         logic [7:0]  frames_ff;
         logic        ovf_ff;

         logic [7:0]  idx_ff;
         logic [19:0] ofs_ff;
         logic [31:0] addr_ff;

         logic        ctrl_wr;
         logic        ctrl_lane0;
         logic        ctrl_lane1;
         logic        ovf_clear;
         logic        ovf_event;

         logic        wrap;
         logic [7:0]  nxt_idx;
         logic [19:0] nxt_ofs;

         logic [31:0] m_enable;
         logic [31:0] m_base;
         logic [31:0] m_stride;
         logic [31:0] m_bytes;
         logic [31:0] m_frames;

         assign wr_sel[c] = wr_fire && wr_chan_hit && (int'(wr_ch) == c);
         assign ctrl_wr   = wr_sel[c] && (wr_reg == REG_ERR_CTRL);

         // action bits are strobes only; they are never stored
         assign ctrl_lane0   = ctrl_wr && i_wstrb[0];
         assign ctrl_lane1   = ctrl_wr && i_wstrb[1];
         assign eq_bus.pop   = ctrl_lane0 && i_wdata[BIT_POP];
         assign eq_bus.flush = ctrl_lane0 && i_wdata[BIT_FLUSH];
         assign ovf_clear    = ctrl_lane1 && i_wdata[BIT_OVF_CLEAR];

         assign eq_bus.push      = i_err_valid && (int'(i_err_ch) == c);
         assign eq_bus.push_data = err_entry;
         // full with no pop or flush beside it: the entry is lost
         assign ovf_event = eq_bus.push && eq_bus.full && !eq_bus.pop && !eq_bus.flush;

         // ==========================================================
         // register read view
         assign chan_word[c][0] = 32'h00000000;
         assign chan_word[c][1] = {23'h0, ovf_ff, 3'h0, eq_bus.count};
         assign chan_word[c][2] = eq_bus.head;
         assign chan_word[c][3] = {16'h0000, next_cid_ff, 7'h00, run_ff};
         assign chan_word[c][4] = {base_ff, 2'b00};
         assign chan_word[c][5] = {20'h00000, stride_ff, 2'b00};
         assign chan_word[c][6] = {20'h00000, bytes_ff, 2'b00};
         assign chan_word[c][7] = {24'h000000, frames_ff};

         assign m_enable = (chan_word[c][3] & ~wmask) | (i_wdata & wmask);
         assign m_base   = (chan_word[c][4] & ~wmask) | (i_wdata & wmask);
         assign m_stride = (chan_word[c][5] & ~wmask) | (i_wdata & wmask);
         assign m_bytes  = (chan_word[c][6] & ~wmask) | (i_wdata & wmask);
         assign m_frames = (chan_word[c][7] & ~wmask) | (i_wdata & wmask);

         // ==========================================================
         // circular frame walk; a zero frame count wraps every frame
         assign wrap    = ({1'b0, idx_ff} + 9'h001) >= {1'b0, frames_ff};
         assign nxt_idx = !run_ff ? 8'h00 :
                          !i_frame_advance[c] ? idx_ff :
                          wrap ? 8'h00 : idx_ff + 8'h01;
         assign nxt_ofs = !run_ff ? 20'h00000 :
                          !i_frame_advance[c] ? ofs_ff :
                          wrap ? 20'h00000 : ofs_ff + {8'h00, stride_ff, 2'b00};

         assign active_cid[c] = active_cid_ff;
         assign cfg_status[c] = !run_ff ? CS_NONE : (active_cid_ff[0] ? CS_B : CS_A);

         always_ff @(posedge i_core_clk) begin
            if (i_sys_rst) begin
               run_ff      <= 1'b0;
               next_cid_ff <= RST_CID;
               base_ff     <= RST_BASE;
               stride_ff   <= RST_STRIDE;
               bytes_ff    <= RST_BYTES;
               frames_ff   <= RST_FRAMES;
            end else if (wr_sel[c]) begin
               case (wr_reg)
                  REG_ENABLE: begin
                     run_ff      <= m_enable[BIT_RUN];
                     next_cid_ff <= m_enable[CID_LSB +: 8];
                  end
                  REG_BUF_BASE: begin
                     base_ff <= m_base[31:2];
                  end
                  REG_FRAME_STRIDE: begin
                     stride_ff <= m_stride[11:2];
                  end
                  REG_FRAME_BYTES: begin
                     bytes_ff <= m_bytes[11:2];
                  end
                  REG_FRAMES: begin
                     frames_ff <= m_frames[7:0];
                  end
                  default: begin
                     frames_ff <= frames_ff;
                  end
               endcase
            end
         end

         always_ff @(posedge i_core_clk) begin
            if (i_sys_rst) begin
               active_cid_ff <= RST_CID;
            end else if (i_superframe_sync) begin
               active_cid_ff <= next_cid_ff;
            end
         end

         // set wins over a clear in the same cycle
         always_ff @(posedge i_core_clk) begin
            if (i_sys_rst) begin
               ovf_ff <= 1'b0;
            end else begin
               ovf_ff <= ovf_event || (ovf_ff && !ovf_clear);
            end
         end

         always_ff @(posedge i_core_clk) begin
            if (i_sys_rst) begin
               idx_ff  <= 8'h00;
               ofs_ff  <= 20'h00000;
               addr_ff <= 32'h00000000;
            end else begin
               idx_ff  <= nxt_idx;
               ofs_ff  <= nxt_ofs;
               addr_ff <= {base_ff, 2'b00} + {12'h000, nxt_ofs};
            end
         end

         tcbq_err_queue #(
            .DEPTH (Q_DEPTH)
         ) u_queue (
            .i_core_clk (i_core_clk),
            .i_sys_rst  (i_sys_rst),
            .eq         (eq_bus.queue)
         );

         // ==========================================================
         // channel outputs
         assign o_channel_run[c]                = run_ff;
         assign o_config_set_b[c]               = active_cid_ff[0];
         assign o_active_config_id[c*8 +: 8]    = active_cid_ff;
         assign o_frame_addr[c*32 +: 32]        = addr_ff;
         assign o_frame_byte_count[c*12 +: 12]  = {bytes_ff, 2'b00};
         assign o_config_set_active_status[c*2 +: 2] = cfg_status[c];
      end
   endgenerate

   // ==========================================================
   // configuration active status word, two bits per channel
   always_comb begin
      status_word = 32'h00000000;
      for (int i = 0; i < NUM_CH; i++) begin
         status_word[i*2 +: 2] = cfg_status[i];
      end
   end

   assign chan_rd_word = chan_word[rd_ch][rd_reg];
   assign rd_word      = rd_chan_hit ? chan_rd_word :
                         rd_glob_hit ? status_word : 32'h00000000;

   // ==========================================================
   // write response
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_map_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // ==========================================================
   // read data
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h00000000;
         rresp_ff  <= RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= rd_word;
         rresp_ff  <= rd_map_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (i_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// [test/tcbq_ctx_props.sv]
// port assertions for the channel context block
`default_nettype none
module tcbq_ctx_props
   import tcbq_pkg::*;
#(parameter int NUM_CH = 6) (
   input wire logic                  i_core_clk,
   input wire logic                  i_sys_rst,
   input wire logic                  i_awvalid,
   input wire logic                  o_awready,
   input wire logic [1:0]            o_bresp,
   input wire logic                  o_bvalid,
   input wire logic                  i_bready,
   input wire logic                  i_arvalid,
   input wire logic                  o_arready,
   input wire logic [31:0]           o_rdata,
   input wire logic                  o_rvalid,
   input wire logic                  i_rready,
   input wire logic                  i_superframe_sync,
   input wire logic [NUM_CH-1:0]     o_channel_run,
   input wire logic [NUM_CH-1:0]     o_config_set_b,
   input wire logic [NUM_CH*8-1:0]   o_active_config_id,
   input wire logic [NUM_CH*32-1:0]  o_frame_addr,
   input wire logic [NUM_CH*12-1:0]  o_frame_byte_count,
   input wire logic [NUM_CH*2-1:0]   o_config_set_active_status
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   // expected status of channel 0 from its run bit and active set
   logic [1:0] exp_cs;
   assign exp_cs = o_channel_run[0] ? {o_config_set_b[0], ~o_config_set_b[0]} : 2'b00;
   // ==============================
   // handshake and context checks
   wr_answer_a: assert property (i_awvalid && o_awready |=> o_bvalid)
      else $error("write answer late");
   b_stands_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write answer dropped");
   rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   r_stands_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read answer dropped");
   cid_hold_a: assert property (!i_superframe_sync |=> $stable(o_active_config_id))
      else $error("config id moved without sync");
   set_pick_a: assert property (o_config_set_b[0] == o_active_config_id[0])
      else $error("set select differs from id bit");
   cfg_status_a: assert property (o_config_set_active_status[1:0] == exp_cs)
      else $error("config status wrong");
   addr_align_a: assert property (o_frame_addr[1:0] == 2'b00)
      else $error("frame address not word aligned");
   size_align_a: assert property (o_frame_byte_count[1:0] == 2'b00)
      else $error("frame byte count not word aligned");
   cover property (i_superframe_sync ##1 o_config_set_b[0]);
   cover property (o_bvalid && o_bresp == RESP_SLVERR);
   cover property (o_rvalid && i_rready);
endmodule
bind tcbq_channel_ctx tcbq_ctx_props #(.NUM_CH(NUM_CH)) props_u (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
   .i_awvalid(i_awvalid), .o_awready(o_awready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
   .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_rready(i_rready),
   .i_superframe_sync(i_superframe_sync), .o_channel_run(o_channel_run), .o_config_set_b(o_config_set_b),
   .o_active_config_id(o_active_config_id), .o_frame_addr(o_frame_addr),
   .o_frame_byte_count(o_frame_byte_count), .o_config_set_active_status(o_config_set_active_status));
`default_nettype wire

// [test/tcbq_engine_model.sv]
// transfer engine model: sync, frame advance, frame count and error events
`default_nettype none
module tcbq_engine_model
   import tcbq_pkg::*;
#(parameter int NUM_CH = 6) (
   input  wire logic         i_core_clk,
   output logic              o_sync,
   output logic [NUM_CH-1:0] o_adv,
   output logic [23:0]       o_fcnt,
   output logic              o_err_valid,
   output logic [2:0]        o_err_ch,
   output logic [1:0]        o_err_cat,
   output logic [7:0]        o_err_code,
   output logic [7:0]        o_err_cid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {o_sync, o_adv, o_fcnt, o_err_valid, o_err_ch, o_err_cat, o_err_code, o_err_cid} = '0;
   // free-running frame count, sampled by the block on frame-time errors
   always @(posedge i_core_clk) begin
      o_fcnt <= o_fcnt + 24'h1;
   end
   // one-cycle superframe sync and per-channel frame advance pulses
   task automatic pulse(input logic s, input logic [NUM_CH-1:0] m);
      @(posedge i_core_clk);
      {o_sync, o_adv} <= {s, m};
      @(posedge i_core_clk);
      {o_sync, o_adv} <= '0;
   endtask
   // one error event; snap is the frame count the block samples with it
   task automatic push(input logic [2:0] ch, input logic [1:0] cat, input logic [7:0] code,
                       input logic [7:0] cid, output logic [23:0] snap);
      @(posedge i_core_clk);
      {o_err_valid, o_err_ch, o_err_cat, o_err_code, o_err_cid} <= {1'b1, ch, cat, code, cid};
      snap = o_fcnt + 24'h1;
      @(posedge i_core_clk);
      // idle fields move away from the last event
      {o_err_valid, o_err_code, o_err_cid} <= {1'b0, ~code, ~cid};
   endtask
endmodule
`default_nettype wire

// [test/tb_tcbq_channel_ctx.sv]
// self-checking bench for the channel context block
`default_nettype none
module tb_tcbq_channel_ctx
   import tcbq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk, rst, awv, awr, wvl, wrd, bv, brd, arv, arr, rvl, rrd, sync, ev;
   logic [11:0]  awa, ara, cst;
   logic [31:0]  wd, rdat, rv;
   logic [3:0]   ws;
   logic [1:0]   bre, rre, ecat, rsp;
   logic [5:0]   adv, run, setb;
   logic [23:0]  fcnt, s1, sn;
   logic [2:0]   ech;
   logic [7:0]   ecode, ecid;
   logic [47:0]  acid;
   logic [191:0] fad;
   logic [71:0]  fby;
   int           num_errors = 0;
   int           compares = 0;
   logic [2:0]   ti [5] = '{REG_BUF_BASE, REG_FRAME_STRIDE, REG_FRAME_BYTES, REG_FRAMES, REG_ERR_CTRL};
   logic [31:0]  te [5] = '{32'hfffffffc, 32'hffc, 32'hffc, 32'hff, 32'h0};
   logic [31:0]  fe [4] = '{32'h1040, 32'h1080, 32'h1000, 32'h1040};
   logic [31:0]  ent [4];
   tcbq_channel_ctx dut_u (.i_core_clk(clk), .i_sys_rst(rst), .i_awaddr(awa), .i_awvalid(awv),
      .o_awready(awr), .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wvl), .o_wready(wrd), .o_bresp(bre),
      .o_bvalid(bv), .i_bready(brd), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdat),
      .o_rresp(rre), .o_rvalid(rvl), .i_rready(rrd), .i_superframe_sync(sync), .i_frame_advance(adv),
      .i_frame_counter(fcnt), .i_err_valid(ev), .i_err_ch(ech), .i_err_cat(ecat), .i_err_code(ecode),
      .i_err_buf_cid(ecid), .o_channel_run(run), .o_config_set_b(setb), .o_active_config_id(acid),
      .o_frame_addr(fad), .o_frame_byte_count(fby), .o_config_set_active_status(cst));
   tcbq_engine_model eng_u (.i_core_clk(clk), .o_sync(sync), .o_adv(adv), .o_fcnt(fcnt), .o_err_valid(ev),
      .o_err_ch(ech), .o_err_cat(ecat), .o_err_code(ecode), .o_err_cid(ecid));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==============================
   // bus tasks and checks
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wt(ref logic s);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (n > 100) chk(32'h0, 32'h1);
         if (n > 100) close_out();
      end while (s !== 1'b1);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {awa, wd, awv, wvl, brd} <= {a, d, 3'b111};
      wt(awr);
      chk({31'h0, wrd}, 32'h1);
      {awv, wvl} <= 2'b00;
      wt(bv);
      rsp = bre;
      brd <= 1'b0;
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      {ara, arv, rrd} <= {a, 2'b11};
      wt(arr);
      arv <= 1'b0;
      wt(rvl);
      {rv, rsp} = {rdat, rre};
      rrd <= 1'b0;
      chk(rv, e);
   endtask
   function automatic logic [11:0] ra(input int c, input logic [2:0] i);
      return 12'(c << CH_SHIFT) | {7'h0, i, 2'b00};
   endfunction
   // ==============================
   // main sequence
   initial begin
      rst = 1'b1;
      {awa, ara, wd, awv, wvl, brd, arv, rrd} = '0;
      ws = 4'hf;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         wr(ra(0, ti[i]), 32'hffffffff);
         rc(ra(0, ti[i]), te[i]);
      end
      chk({20'h0, fby[11:0]}, 32'hffc);
      wr(ra(5, REG_BUF_BASE), 32'h12345677);
      rc(ra(5, REG_BUF_BASE), 32'h12345674);
      ws <= 4'h1;
      wr(ra(5, REG_BUF_BASE), 32'hffffffff);
      ws <= 4'hf;
      rc(ra(5, REG_BUF_BASE), 32'h123456fc);
      chk({30'h0, rsp}, {30'h0, RESP_OKAY});
      wr(12'hfc0, 32'h1);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      rc(12'hfc0, 32'h0);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      $display("test 1 done");
      wr(ra(0, REG_BUF_BASE), 32'h1000);
      wr(ra(0, REG_FRAME_STRIDE), 32'h40);
      wr(ra(0, REG_FRAMES), 32'h3);
      wr(ra(0, REG_ENABLE), 32'h1);
      @(posedge clk);
      chk(fad[31:0], 32'h1000);
      for (int k = 0; k < 4; k++) begin
         eng_u.pulse(1'b0, 6'h01);
         @(posedge clk);
         chk(fad[31:0], fe[k]);
      end
      wr(ra(0, REG_ENABLE), 32'h0);
      eng_u.pulse(1'b0, 6'h01);
      @(posedge clk);
      chk(fad[31:0], 32'h1000);
      rc(OFS_CFG_STATUS, 32'h0);
      $display("test 2 done");
      wr(ra(0, REG_ENABLE), 32'h0501);
      rc(OFS_CFG_STATUS, 32'h1);
      eng_u.pulse(1'b1, 6'h00);
      @(posedge clk);
      chk({24'h0, acid[7:0]}, 32'h5);
      rc(OFS_CFG_STATUS, 32'h2);
      wr(ra(0, REG_ENABLE), 32'h0401);
      eng_u.pulse(1'b1, 6'h00);
      rc(OFS_CFG_STATUS, 32'h1);
      $display("test 3 done");
      eng_u.push(3'h0, CAT_FRAME_TIME, 8'ha1, 8'h00, s1);
      eng_u.push(3'h0, CAT_CID_PAIR, 8'hb2, 8'h3c, sn);
      eng_u.push(3'h0, CAT_CID_ACTIVE, 8'hc3, 8'h77, sn);
      eng_u.push(3'h0, CAT_CODE_ONLY, 8'hd4, 8'h55, sn);
      ent = '{{8'ha1, s1}, {8'hb2, 8'h00, 8'h04, 8'h3c}, {8'hc3, 16'h0, 8'h04}, {8'hd4, 24'h0}};
      for (int i = 0; i < 4; i++) begin
         rc(ra(0, REG_ERR_QUEUE), ent[i]);
         rc(ra(0, REG_ERR_COUNT), 32'(4 - i));
         wr(ra(0, REG_ERR_CTRL), 32'h1);
      end
      rc(ra(0, REG_ERR_COUNT), 32'h0);
      for (int j = 0; j < 2; j++) eng_u.push(3'h0, CAT_CODE_ONLY, 8'h11, 8'h00, sn);
      wr(ra(0, REG_ERR_CTRL), 32'h2);
      rc(ra(0, REG_ERR_COUNT), 32'h0);
      for (int j = 0; j < 17; j++) eng_u.push(3'h0, CAT_CODE_ONLY, 8'(j), 8'h00, sn);
      rc(ra(0, REG_ERR_COUNT), 32'h110);
      wr(ra(0, REG_ERR_CTRL), 32'h1);
      rc(ra(0, REG_ERR_COUNT), 32'h10f);
      rc(ra(0, REG_ERR_QUEUE), 32'h01000000);
      wr(ra(0, REG_ERR_CTRL), 32'h0);
      rc(ra(0, REG_ERR_COUNT), 32'h10f);
      wr(ra(0, REG_ERR_CTRL), 32'h100);
      rc(ra(0, REG_ERR_COUNT), 32'h00f);
      $display("test 4 done");
      close_out();
   end
endmodule
`default_nettype wire
